// [sep_prioritizer.sv]
// synchronous exception prioritizer for priorities 14 to 31 with fp trap syndrome

`timescale 1ns/100ps
`include "sep_cfg.svh"

module sep_prioritizer (
   // clock and reset
   input  wire logic                        clk_in,
   input  wire logic                        reset_in,
   // apb slave
   input  wire logic                        psel_in,
   input  wire logic                        penable_in,
   input  wire logic                        pwrite_in,
   input  wire logic [7:0]                  paddr_in,
   input  wire logic [31:0]                 pwdata_in,
   output logic      [31:0]                 prdata_out,
   output logic                             pready_out,
   output logic                             pslverr_out,
   // pipeline candidates
   input  wire logic                        insn_valid_in,
   input  wire sep_pkg::sep_level_t         cur_level_in,
   input  wire logic [`SEP_NUM_CAND-1:0]    cand_in,
   input  wire logic                        ext_abort_in,
   input  wire logic                        call_insn_in,
   input  wire sep_pkg::sep_call_t          call_kind_in,
   input  wire logic [`SEP_NUM_ELEM*`SEP_FP_W-1:0] fp_elem_flags_in,
   // selected exception
   output logic                             exc_valid_out,
   output logic      [4:0]                  exc_prio_out,
   output sep_pkg::sep_level_t              exc_target_out,
   output logic                             exc_undef_out,
   output logic      [`SEP_FP_W-1:0]        fp_trap_bits_out,
   output logic      [1:0]                  fp_elem_out,
   output logic                             fp_restore_out
);

   ////////////////////////////////////////////////////////////////////////////
   // registers

   logic [`SEP_CTRL_W-1:0]     ctrl_r;
   logic [`SEP_FP_W-1:0]       fp_en_r;
   logic                       tgr;
   logic                       secure_call_disable;
   logic                       undef_rank;
   logic                       ea_at_29;
   logic                       restore_en;
   logic                       apb_setup;
   logic                       apb_write;
   logic                       addr_ok;
   logic [31:0]                rd_data;

   assign tgr        = ctrl_r[`SEP_CTRL_TGR];
   assign secure_call_disable        = ctrl_r[`SEP_CTRL_SMD];
   assign undef_rank = ctrl_r[`SEP_CTRL_UNDEF];
   assign ea_at_29   = ctrl_r[`SEP_CTRL_EA29];
   assign restore_en = ctrl_r[`SEP_CTRL_RESTORE];

   assign apb_setup = psel_in && !penable_in;
   // write lands at the access edge, where pready is already high
   assign apb_write = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;

   always_comb begin
      addr_ok = 1'b1;
      rd_data = 32'h0000_0000;
      case (paddr_in)
         `SEP_ADDR_CTRL:  rd_data = {27'h0, ctrl_r};
         `SEP_ADDR_FPCTL: rd_data = {26'h0, fp_en_r};
         `SEP_ADDR_STAT:  rd_data = {23'h0, exc_undef_out, exc_valid_out,
                                     exc_target_out, exc_prio_out};
         `SEP_ADDR_FPSYN: rd_data = {24'h0, fp_elem_out, fp_trap_bits_out};
         default:         addr_ok = 1'b0;
      endcase
   end

   // one wait-free answer: pready rises in the access phase right after setup
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end else begin
         pready_out  <= apb_setup;
         pslverr_out <= apb_setup && !addr_ok;
         prdata_out  <= (apb_setup && !pwrite_in) ? rd_data : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         ctrl_r  <= `SEP_CTRL_RST;
         fp_en_r <= `SEP_FPCTL_RST;
      end else if (apb_write) begin
         if (paddr_in == `SEP_ADDR_CTRL) begin
            ctrl_r <= pwdata_in[`SEP_CTRL_W-1:0];
         end
         if (paddr_in == `SEP_ADDR_FPCTL) begin
            // unsupported types keep a zero enable and can never trap
            fp_en_r <= pwdata_in[`SEP_FP_W-1:0] & `SEP_FP_SUPPORTED;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // fp trap detection per simd element

   logic [`SEP_FP_W-1:0]       elem_trap [`SEP_NUM_ELEM];
   logic [`SEP_NUM_ELEM-1:0]   elem_any;
   logic [`SEP_FP_W-1:0]       fp_pick;
   logic [`SEP_FP_W-1:0]       fp_onehot;
   logic [1:0]                 fp_elem;
   logic                       fp_any;

   genvar e;
   generate
      for (e = 0; e < `SEP_NUM_ELEM; e = e + 1) begin : g_elem
         assign elem_trap[e] = fp_elem_flags_in[e*`SEP_FP_W +: `SEP_FP_W]
                               & fp_en_r & `SEP_FP_SUPPORTED;
         assign elem_any[e]  = |elem_trap[e];
      end
   endgenerate

   // lowest faulting element is reported; any one element is allowed
   always_comb begin
      fp_pick = '0;
      fp_elem = 2'h0;
      for (int i = `SEP_NUM_ELEM - 1; i >= 0; i--) begin
         if (elem_any[i]) begin
            fp_pick = elem_trap[i];
            fp_elem = i[1:0];
         end
      end
   end

   // lowest set bit is the highest priority type; others read zero
   assign fp_onehot = fp_pick & (~fp_pick + 6'h01);
   assign fp_any    = `SEP_SIMD_FP_IMPL && (|elem_any);

   ////////////////////////////////////////////////////////////////////////////
   // candidate collection

   logic [`SEP_NUM_CAND-1:0]   pend;
   logic                       smc_off;
   logic                       undef_defer;

   assign smc_off = call_insn_in && (call_kind_in == sep_pkg::SEP_CALL_SMC) && secure_call_disable;

   always_comb begin
      pend = cand_in;
      pend[`SEP_IDX_SMD]  = smc_off;
      pend[`SEP_IDX_CALL] = call_insn_in && !smc_off
                            && (call_kind_in != sep_pkg::SEP_CALL_NONE);
      pend[`SEP_IDX_FPAC] = cand_in[`SEP_IDX_FPAC] && `SEP_FPAC_IMPL;
      pend[`SEP_IDX_FP]   = fp_any;
      // several atomic accesses fold into one abort flag, no order among them
      if (ext_abort_in) begin
         if (ea_at_29) begin
            pend[`SEP_IDX_EA29] = 1'b1;
         end else begin
            pend[`SEP_IDX_DA31] = 1'b1;
         end
      end
      // level 3 traps other than SEC32 handed to the undefined-instruction rank outside this block
      if (undef_rank) begin
         pend[`SEP_IDX_MFEAT] = 1'b0;
         pend[`SEP_IDX_MDBG]  = 1'b0;
         pend[`SEP_IDX_ACC3]  = 1'b0;
      end
   end

   assign undef_defer = undef_rank && (cand_in[`SEP_IDX_MFEAT] || cand_in[`SEP_IDX_MDBG]
                                       || cand_in[`SEP_IDX_ACC3]);

   ////////////////////////////////////////////////////////////////////////////
   // selection and target

   logic [4:0]                 sel_idx;
   logic                       sel_any;
   sep_pkg::sep_level_t        sel_tgt;
   sep_pkg::sep_level_t        redirect_lvl;
   sep_pkg::sep_level_t        generic_lvl;

   // all candidates are looked at together; lowest index wins
   always_comb begin
      sel_idx = 5'h00;
      for (int i = `SEP_NUM_CAND - 1; i >= 0; i--) begin
         if (pend[i]) begin
            sel_idx = i[4:0];
         end
      end
   end

   assign sel_any      = |pend;
   assign redirect_lvl = tgr ? sep_pkg::SEP_PL2 : sep_pkg::SEP_PL1;
   assign generic_lvl  = (cur_level_in == sep_pkg::SEP_PL0) ? redirect_lvl : cur_level_in;

   always_comb begin
      case (sel_idx)
         `SEP_IDX_CFG_TRAP: sel_tgt = redirect_lvl;
         `SEP_IDX_SYSREG:   sel_tgt = sep_pkg::SEP_PL2;
         `SEP_IDX_FEAT:     sel_tgt = sep_pkg::SEP_PL2;
         `SEP_IDX_HCFG:     sel_tgt = sep_pkg::SEP_PL2;
         `SEP_IDX_ACC2:     sel_tgt = sep_pkg::SEP_PL2;
         `SEP_IDX_CALL: begin
            case (call_kind_in)
               sep_pkg::SEP_CALL_HVC: sel_tgt = sep_pkg::SEP_PL2;
               sep_pkg::SEP_CALL_SMC: sel_tgt = sep_pkg::SEP_PL3;
               default:               sel_tgt = generic_lvl;
            endcase
         end
         `SEP_IDX_MFEAT:    sel_tgt = sep_pkg::SEP_PL3;
         `SEP_IDX_SEC32:    sel_tgt = sep_pkg::SEP_PL3;
         `SEP_IDX_MDBG:     sel_tgt = sep_pkg::SEP_PL3;
         `SEP_IDX_ACC3:     sel_tgt = sep_pkg::SEP_PL3;
         `SEP_IDX_FP:       sel_tgt = generic_lvl;
         default:           sel_tgt = generic_lvl;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, one cycle after the candidates

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         exc_valid_out  <= 1'b0;
         exc_prio_out   <= 5'h00;
         exc_target_out <= sep_pkg::SEP_PL0;
         exc_undef_out  <= 1'b0;
      end else begin
         exc_valid_out  <= insn_valid_in && sel_any;
         exc_prio_out   <= (insn_valid_in && sel_any) ? `SEP_PRIO_BASE + sel_idx : 5'h00;
         exc_target_out <= (insn_valid_in && sel_any) ? sel_tgt : sep_pkg::SEP_PL0;
         exc_undef_out  <= insn_valid_in && undef_defer;
      end
   end

   // syndrome bits only when the fp trap is the one taken
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         fp_trap_bits_out <= '0;
         fp_elem_out      <= 2'h0;
         fp_restore_out   <= 1'b0;
      end else begin
         if (insn_valid_in && sel_any && sel_idx == `SEP_IDX_FP) begin
            fp_trap_bits_out <= fp_onehot;
            fp_elem_out      <= fp_elem;
         end else begin
            fp_trap_bits_out <= '0;
            fp_elem_out      <= 2'h0;
         end
         // restore pulse lets the fp unit roll its status back
         fp_restore_out <= insn_valid_in && sel_any && (sel_idx == `SEP_IDX_FP)
                           && restore_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_one_cycle;
      @(posedge clk_in) disable iff (reset_in)
      (insn_valid_in && (|pend)) |=> exc_valid_out && exc_prio_out >= 5'h0e
                                      && exc_prio_out <= 5'h1f;
   endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("selected exception missing one cycle after candidates");

   property p_rank14;
      @(posedge clk_in) disable iff (reset_in)
      (insn_valid_in && cand_in[0]) |=> exc_prio_out == 5'h0e
                                        && exc_target_out == ($past(tgr) ? 2'b10 : 2'b01);
   endproperty
   a_rank14: assert property (p_rank14)
      else $error("priority 14 not chosen or wrong target");

   property p_sysreg_target;
      @(posedge clk_in) disable iff (reset_in)
      (exc_valid_out && exc_prio_out == 5'h0f) |-> exc_target_out == sep_pkg::SEP_PL2;
   endproperty
   a_sysreg_target: assert property (p_sysreg_target)
      else $error("priority 15 not sent to level 2");

   property p_smc_off;
      @(posedge clk_in) disable iff (reset_in)
      (insn_valid_in && smc_off && cand_in[4:0] == 5'h00) |=> exc_prio_out == 5'h13;
   endproperty
   a_smc_off: assert property (p_smc_off)
      else $error("disabled secure call not ranked 19");

   property p_call;
      @(posedge clk_in) disable iff (reset_in)
      (insn_valid_in && call_insn_in && !smc_off && call_kind_in != sep_pkg::SEP_CALL_NONE
       && cand_in[5:0] == 6'h00) |=> exc_prio_out == 5'h14;
   endproperty
   a_call: assert property (p_call)
      else $error("call instruction not ranked 20");

   property p_fp_route;
      @(posedge clk_in) disable iff (reset_in)
      (exc_valid_out && exc_prio_out == 5'h1a && $past(cur_level_in) == sep_pkg::SEP_PL0)
      |-> exc_target_out == ($past(tgr) ? sep_pkg::SEP_PL2 : sep_pkg::SEP_PL1);
   endproperty
   a_fp_route: assert property (p_fp_route)
      else $error("fp trap from level 0 routed wrongly");

   property p_fp_onehot;
      @(posedge clk_in) disable iff (reset_in)
      $onehot0(fp_trap_bits_out) && (fp_trap_bits_out == '0 || exc_prio_out == 5'h1a);
   endproperty
   a_fp_onehot: assert property (p_fp_onehot)
      else $error("trapped fp bits not single or not with priority 26");

   property p_fp_gate;
      @(posedge clk_in) disable iff (reset_in)
      ##1 (fp_trap_bits_out & ~$past(fp_en_r)) == '0;
   endproperty
   a_fp_gate: assert property (p_fp_gate)
      else $error("fp trap reported for a disabled type");

   property p_restore;
      @(posedge clk_in) disable iff (reset_in)
      fp_restore_out |-> exc_prio_out == 5'h1a && $past(restore_en);
   endproperty
   a_restore: assert property (p_restore)
      else $error("fp status restore without a taken fp trap");

endmodule // sep_prioritizer

// [sep_cfg.svh]
// offsets, field positions, reset values and fixed counts of the prioritizer
`ifndef SEP_CFG_SVH
`define SEP_CFG_SVH

// apb register byte addresses
`define SEP_ADDR_CTRL      8'h00
`define SEP_ADDR_FPCTL     8'h04
`define SEP_ADDR_STAT      8'h08
`define SEP_ADDR_FPSYN     8'h0c

// control register fields
`define SEP_CTRL_TGR       0
`define SEP_CTRL_SMD       1
`define SEP_CTRL_UNDEF     2
`define SEP_CTRL_EA29      3
`define SEP_CTRL_RESTORE   4
`define SEP_CTRL_W         5
`define SEP_CTRL_RST       5'h00

// fp exception types, bit 0 is the highest trap priority
`define SEP_FP_W           6
`define SEP_FP_INVALID     0
`define SEP_FP_DIVZERO     1
`define SEP_FP_OVERFLOW    2
`define SEP_FP_UNDERFLOW   3
`define SEP_FP_INEXACT     4
`define SEP_FP_DENORMAL    5
`define SEP_FP_SUPPORTED   6'h3f
`define SEP_FPCTL_RST      6'h00

// implemented features
`define SEP_FPAC_IMPL      1'b1
`define SEP_SIMD_FP_IMPL   1'b1

// candidate vector, index 0 is priority 14
`define SEP_NUM_CAND       18
`define SEP_PRIO_BASE      5'h0e
`define SEP_IDX_CFG_TRAP   5'd0
`define SEP_IDX_SYSREG     5'd1
`define SEP_IDX_FEAT       5'd2
`define SEP_IDX_HCFG       5'd3
`define SEP_IDX_ACC2       5'd4
`define SEP_IDX_SMD        5'd5
`define SEP_IDX_CALL       5'd6
`define SEP_IDX_MFEAT      5'd7
`define SEP_IDX_SEC32      5'd8
`define SEP_IDX_MDBG       5'd9
`define SEP_IDX_ACC3       5'd10
`define SEP_IDX_FPAC       5'd11
`define SEP_IDX_FP         5'd12
`define SEP_IDX_DEBUG      5'd13
`define SEP_IDX_SPALIGN    5'd14
`define SEP_IDX_EA29       5'd15
`define SEP_IDX_WATCH      5'd16
`define SEP_IDX_DA31       5'd17

// simd elements examined per fp instruction
`define SEP_NUM_ELEM       4

`endif

// [sep_pkg.sv]
// types shared by the synchronous exception prioritizer
package sep_pkg;

   typedef enum logic [1:0] {
      SEP_PL0 = 2'b00,
      SEP_PL1 = 2'b01,
      SEP_PL2 = 2'b10,
      SEP_PL3 = 2'b11
   } sep_level_t;

   typedef enum logic [1:0] {
      SEP_CALL_NONE = 2'b00,
      SEP_CALL_SVC  = 2'b01,
      SEP_CALL_HVC  = 2'b10,
      SEP_CALL_SMC  = 2'b11
   } sep_call_t;

endpackage

// [sep_pipe_model.sv]
// pipeline stand-in that presents the candidates of one instruction at a time
`timescale 1ns/100ps
`include "sep_cfg.svh"

module sep_pipe_model (
   // clock
   input  wire logic                                clk_in,
   // candidates toward the prioritizer
   output logic                                     insn_valid_out,
   output sep_pkg::sep_level_t                      cur_level_out,
   output logic [`SEP_NUM_CAND-1:0]                 cand_out,
   output logic                                     ext_abort_out,
   output logic                                     call_insn_out,
   output sep_pkg::sep_call_t                       call_kind_out,
   output logic [`SEP_NUM_ELEM*`SEP_FP_W-1:0]       fp_flags_out
);
   initial begin
      insn_valid_out = 1'b0;
      cur_level_out = sep_pkg::SEP_PL0;
      cand_out = '0;
      ext_abort_out = 1'b0;
      call_insn_out = 1'b0;
      call_kind_out = sep_pkg::SEP_CALL_NONE;
      fp_flags_out = '0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one instruction for one cycle; idle candidate, abort and fp fields are left inverted, level and call fields held
   task automatic issue(input sep_pkg::sep_level_t lvl, input logic [17:0] cand,
                        input logic ea, input sep_pkg::sep_call_t ck, input logic [23:0] fp);
      @(posedge clk_in);
      insn_valid_out <= 1'b1;
      cur_level_out <= lvl;
      cand_out <= cand;
      ext_abort_out <= ea;
      call_insn_out <= (ck != sep_pkg::SEP_CALL_NONE);
      call_kind_out <= ck;
      fp_flags_out <= fp;
      @(posedge clk_in);
      insn_valid_out <= 1'b0;
      cand_out <= ~cand;
      ext_abort_out <= ~ea;
      fp_flags_out <= ~fp;
   endtask
endmodule // sep_pipe_model

// [tb_sep_prioritizer.sv]
// self-checking bench for the synchronous exception prioritizer
`timescale 1ns/100ps
`include "sep_cfg.svh"

module tb_sep_prioritizer;
   logic                             clk_in;
   logic                             reset_in;
   logic                             psel_in;
   logic                             penable_in;
   logic                             pwrite_in;
   logic [7:0]                       paddr_in;
   logic [31:0]                      pwdata_in;
   logic [31:0]                      prdata_out;
   logic                             pready_out;
   logic                             pslverr_out;
   logic                             insn_valid_in;
   sep_pkg::sep_level_t              cur_level_in;
   logic [`SEP_NUM_CAND-1:0]         cand_in;
   logic                             ext_abort_in;
   logic                             call_insn_in;
   sep_pkg::sep_call_t               call_kind_in;
   logic [`SEP_NUM_ELEM*`SEP_FP_W-1:0] fp_elem_flags_in;
   logic                             exc_valid_out;
   logic [4:0]                       exc_prio_out;
   sep_pkg::sep_level_t              exc_target_out;
   logic                             exc_undef_out;
   logic [`SEP_FP_W-1:0]             fp_trap_bits_out;
   logic [1:0]                       fp_elem_out;
   logic                             fp_restore_out;
   int                               errors;
   int                               checks_done;
   logic [31:0]                      rd;
   logic                             er;

   sep_prioritizer sep_prioritizer_i (.clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .insn_valid_in(insn_valid_in), .cur_level_in(cur_level_in),
      .cand_in(cand_in), .ext_abort_in(ext_abort_in), .call_insn_in(call_insn_in),
      .call_kind_in(call_kind_in), .fp_elem_flags_in(fp_elem_flags_in),
      .exc_valid_out(exc_valid_out), .exc_prio_out(exc_prio_out),
      .exc_target_out(exc_target_out), .exc_undef_out(exc_undef_out),
      .fp_trap_bits_out(fp_trap_bits_out), .fp_elem_out(fp_elem_out),
      .fp_restore_out(fp_restore_out));

   sep_pipe_model sep_pipe_model_i (.clk_in(clk_in), .insn_valid_out(insn_valid_in),
      .cur_level_out(cur_level_in), .cand_out(cand_in), .ext_abort_out(ext_abort_in),
      .call_insn_out(call_insn_in), .call_kind_out(call_kind_in),
      .fp_flags_out(fp_elem_flags_in));

   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // apb transfer; allows the slave up to 20 cycles before giving up
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= wd;
      @(posedge clk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      if (pready_out !== 1'b1) begin
         errors++;
         report_and_stop();
      end else begin
         rd = prdata_out;
         er = pslverr_out;
         psel_in <= 1'b0;
         penable_in <= 1'b0;
      end
   endtask

   function automatic logic [1:0] gen(input int l, input int g);
      return (l == 0) ? (g != 0 ? 2'd2 : 2'd1) : 2'(l);
   endfunction

   task automatic expect_exc(input string nm, input logic v, input logic [4:0] p,
                             input logic [1:0] t);
      @(negedge clk_in);
      check({nm, " valid"}, 32'(exc_valid_out), 32'(v));
      check({nm, " prio"}, 32'(exc_prio_out), 32'(p));
      check({nm, " target"}, 32'(exc_target_out), 32'(t));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic sc_regs();
      apb(1'b0, `SEP_ADDR_CTRL, 32'h0);
      check("ctrl reset", rd, 32'(`SEP_CTRL_RST));
      apb(1'b0, `SEP_ADDR_FPCTL, 32'h0);
      check("fpctl reset", rd, 32'(`SEP_FPCTL_RST));
      apb(1'b1, `SEP_ADDR_CTRL, 32'hffffffff);
      apb(1'b1, `SEP_ADDR_FPCTL, 32'hffffffff);
      apb(1'b1, 8'h10, 32'h0);
      check("unmapped err", 32'(er), 32'h1);
      apb(1'b0, 8'h10, 32'h0);
      check("unmapped data", rd, 32'h0);
      apb(1'b0, `SEP_ADDR_CTRL, 32'h0);
      check("ctrl rw", rd, 32'h1f);
      apb(1'b0, `SEP_ADDR_FPCTL, 32'h0);
      check("fpctl rw", rd, 32'h3f);
   endtask

   // every candidate index except 5, 6 and 12 with all lower-ranked ones raised alongside
   task automatic sc_ranks();
      logic [1:0] t;
      for (int g = 0; g < 2; g++) begin
         apb(1'b1, `SEP_ADDR_CTRL, 32'(g));
         for (int l = 0; l < 4; l++) begin
            for (int i = 0; i < `SEP_NUM_CAND; i++) begin
               if (i == 5 || i == 6 || i == 12) continue;
               t = (i == 0) ? (g != 0 ? 2'd2 : 2'd1) : (i < 5) ? 2'd2 :
                   (i > 6 && i < 11) ? 2'd3 : gen(l, g);
               sep_pipe_model_i.issue(sep_pkg::sep_level_t'(l), ~((18'h1 << i) - 18'h1),
                                      1'b0, sep_pkg::SEP_CALL_NONE, 24'h0);
               expect_exc("rank", 1'b1, 5'(14 + i), t);
            end
         end
      end
      sep_pipe_model_i.issue(sep_pkg::SEP_PL1, 18'h01060, 1'b0, sep_pkg::SEP_CALL_NONE, 24'h0);
      expect_exc("internal only", 1'b0, 5'h00, 2'd0);
   endtask

   task automatic sc_calls();
      sep_pkg::sep_call_t k [3] = '{sep_pkg::SEP_CALL_SVC, sep_pkg::SEP_CALL_HVC,
                                    sep_pkg::SEP_CALL_SMC};
      logic [1:0] tg [3] = '{2'd1, 2'd2, 2'd3};
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, `SEP_ADDR_CTRL, s != 0 ? 32'h2 : 32'h0);
         for (int j = 0; j < 3; j++) begin
            sep_pipe_model_i.issue(sep_pkg::SEP_PL0, 18'h02000, 1'b0, k[j], 24'h0);
            if (s != 0 && j == 2) begin
               expect_exc("smc disabled", 1'b1, 5'd19, 2'd1);
            end else begin
               expect_exc("call", 1'b1, 5'd20, tg[j]);
            end
         end
      end
   endtask

   // trap enables peeled off from the top priority type downward
   task automatic sc_fp_order();
      apb(1'b1, `SEP_ADDR_CTRL, 32'h0);
      for (int t = 0; t <= 6; t++) begin
         apb(1'b1, `SEP_ADDR_FPCTL, 32'(6'h3f & ~((6'h1 << t) - 6'h1)));
         sep_pipe_model_i.issue(sep_pkg::SEP_PL3, 18'h0, 1'b0, sep_pkg::SEP_CALL_NONE,
                                {4{6'h3f}});
         expect_exc("fp order", t < 6, t < 6 ? 5'd26 : 5'd0, t < 6 ? 2'd3 : 2'd0);
         check("fp bits", 32'(fp_trap_bits_out), 32'(6'(7'h1 << t)));
         check("fp elem", 32'(fp_elem_out), 32'h0);
         check("fp restore", 32'(fp_restore_out), 32'h0);
      end
   endtask

   task automatic sc_fp_elems();
      apb(1'b1, `SEP_ADDR_CTRL, 32'h11);
      apb(1'b1, `SEP_ADDR_FPCTL, 32'h38);
      sep_pipe_model_i.issue(sep_pkg::SEP_PL0, 18'h02000, 1'b0, sep_pkg::SEP_CALL_NONE,
                             {6'h08, 6'h08, 6'h30, 6'h03});
      expect_exc("fp elem", 1'b1, 5'd26, 2'd2);
      check("fp bits", 32'(fp_trap_bits_out), 32'h10);
      check("fp elem", 32'(fp_elem_out), 32'h1);
      check("fp restore", 32'(fp_restore_out), 32'h1);
      // idle cycle with scrambled candidates
      expect_exc("idle", 1'b0, 5'h00, 2'd0);
   endtask

   // status and syndrome read in the one cycle an fp trap stands
   task automatic sc_status();
      for (int r = 0; r < 2; r++) begin
         fork
            sep_pipe_model_i.issue(sep_pkg::SEP_PL0, 18'h02000, 1'b0, sep_pkg::SEP_CALL_NONE,
                                   {6'h08, 6'h08, 6'h30, 6'h03});
            begin
               @(posedge clk_in);
               apb(1'b0, r != 0 ? `SEP_ADDR_FPSYN : `SEP_ADDR_STAT, 32'h0);
            end
         join
         check("status regs", rd, r != 0 ? 32'h50 : 32'hda);
      end
   endtask

   task automatic sc_undef_abort();
      apb(1'b1, `SEP_ADDR_CTRL, 32'h4);
      sep_pipe_model_i.issue(sep_pkg::SEP_PL1, 18'h00080, 1'b0, sep_pkg::SEP_CALL_NONE, 24'h0);
      @(negedge clk_in);
      check("undef rank", 32'(exc_undef_out), 32'h1);
      check("undef drop", 32'(exc_valid_out), 32'h0);
      sep_pipe_model_i.issue(sep_pkg::SEP_PL1, 18'h00180, 1'b0, sep_pkg::SEP_CALL_NONE, 24'h0);
      expect_exc("sec32", 1'b1, 5'd22, 2'd3);
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, `SEP_ADDR_CTRL, e != 0 ? 32'h8 : 32'h0);
         sep_pipe_model_i.issue(sep_pkg::SEP_PL1, 18'h10000, 1'b1, sep_pkg::SEP_CALL_NONE,
                                24'h0);
         expect_exc("ext watch", 1'b1, e != 0 ? 5'd29 : 5'd30, 2'd1);
         sep_pipe_model_i.issue(sep_pkg::SEP_PL2, 18'h0, 1'b1, sep_pkg::SEP_CALL_NONE, 24'h0);
         expect_exc("ext alone", 1'b1, e != 0 ? 5'd29 : 5'd31, 2'd2);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      errors = 0;
      checks_done = 0;
      reset_in = 1'b1;
      psel_in = 1'b0;
      penable_in = 1'b0;
      pwrite_in = 1'b0;
      paddr_in = 8'h00;
      pwdata_in = 32'h0;
      repeat (20) @(posedge clk_in);
      reset_in <= 1'b0;
      sc_regs();
      sc_ranks();
      sc_calls();
      sc_fp_order();
      sc_fp_elems();
      sc_status();
      sc_undef_abort();
      report_and_stop();
   end
endmodule // tb_sep_prioritizer
